// ---- design/iab_accel_bias_regs.sv ----
// Accelerometer bias register bank with serial command port and user bias stage.
// Assumes factory-corrected samples on the inputs and an external serial host.
//
// Functional notes
// - X offset from lower/upper words, reset zero.
// - Y offset pair, same as X.
// - Z offset pair, same as X.
// - Bias added after factory stage, 2000 Hz.
// - Two cascaded averages of 2^B taps.
// - Range code in bits 3:2, read-only.
// - Range register bits 1:0 read 11.
// - Bit 7 enables linear-g gyro compensation.
// - Bit 6 enables point-of-percussion alignment.
// - Bits 4:2 select sync pin function.
// - Bit 1 selects active sync edge.
// - Bit 0 sets data-ready polarity.
// - Control register resets to 0x00c1.
`timescale 1ns/10ps
module iab_accel_bias_regs
   import iab_pkg::*;
#(
   parameter int         SAMPLE_DIV = SAMPLE_DIV_CYC,
   parameter logic [1:0] GYRO_RANGE = 2'h3
)(
   input  wire  logic                 ref_clk,
   input  wire  logic                 sys_rst,
   input  wire  logic                 spi_cs_n,
   input  wire  logic                 spi_sclk,
   input  wire  logic                 spi_din,
   output logic                       spi_dout,
   output logic                       spi_dout_oe,
   input  wire  logic                 sync_in,
   output logic                       sync_out,
   output logic                       sync_oe,
   input  wire  logic [SAMPLE_W-1:0]  accel_x_in,
   input  wire  logic [SAMPLE_W-1:0]  accel_y_in,
   input  wire  logic [SAMPLE_W-1:0]  accel_z_in,
   output logic [SAMPLE_W-1:0]        accel_x_out,
   output logic [SAMPLE_W-1:0]        accel_y_out,
   output logic [SAMPLE_W-1:0]        accel_z_out,
   output logic                       data_ready_output,
   output logic                       lin_g_comp_en,
   output logic                       pop_align_en,
   output logic [2:0]                 sync_mode
);

   logic [15:0]          offset_word [0:5];
   logic [15:0]          filter_size;
   logic [15:0]          misc_control;
   logic [2:0]           sclk_sync;
   logic [2:0]           cs_sync;
   logic [2:0]           din_sync;
   logic [2:0]           syn_sync;
   logic                 sclk_q;
   logic                 cs_q;
   logic                 syn_q;
   logic                 sclk_rise;
   logic                 sclk_fall;
   logic                 cs_fall;
   logic                 syn_rise;
   logic                 syn_fall;
   iab_link_state_t      link_state;
   logic [4:0]           bit_cnt;
   logic [15:0]          rx_shift;
   logic [15:0]          tx_shift;
   logic [15:0]          tx_hold;
   logic                 word_done;
   logic [15:0]          word;
   logic [6:0]           cmd_addr;
   logic [15:0]          read_word;
   logic                 filter_clear;
   logic [$clog2(SAMPLE_DIV)-1:0] div_cnt;
   logic                 int_tick;
   logic                 ext_edge;
   logic                 sample_tick;
   logic [$clog2(SYNC_PULSE_CYC+1)-1:0] pulse_cnt;
   logic                 dr_valid;
   logic [SAMPLE_W-1:0]  raw_in [0:2];
   logic [SAMPLE_W-1:0]  axis_out [0:2];
   logic [2:0]           axis_valid;

   assign raw_in[0] = accel_x_in;
   assign raw_in[1] = accel_y_in;
   assign raw_in[2] = accel_z_in;

   // Three-stage synchronisers for every pin input
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sclk_sync <= 3'h7;
         cs_sync   <= 3'h7;
         din_sync  <= 3'h0;
         syn_sync  <= 3'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], spi_sclk};
         cs_sync   <= {cs_sync[1:0], spi_cs_n};
         din_sync  <= {din_sync[1:0], spi_din};
         syn_sync  <= {syn_sync[1:0], sync_in};
      end
   end

   // Accepted levels change only when stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sclk_q <= 1'b1;
         cs_q   <= 1'b1;
         syn_q  <= 1'b0;
      end else begin
         if (sclk_sync[1] == sclk_sync[2]) sclk_q <= sclk_sync[2];
         if (cs_sync[1] == cs_sync[2]) cs_q <= cs_sync[2];
         if (syn_sync[1] == syn_sync[2]) syn_q <= syn_sync[2];
      end
   end

   // Edge events on accepted levels
   assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_q;
   assign sclk_fall = (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2] && sclk_q;
   assign cs_fall   = (cs_sync[1] == cs_sync[2]) && !cs_sync[2] && cs_q;
   assign syn_rise  = (syn_sync[1] == syn_sync[2]) && syn_sync[2] && !syn_q;
   assign syn_fall  = (syn_sync[1] == syn_sync[2]) && !syn_sync[2] && syn_q;

   // Serial frame receiver and transmitter, sample on rise, shift on fall
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         link_state <= LINK_IDLE;
         bit_cnt    <= '0;
         rx_shift   <= '0;
         tx_shift   <= '0;
         word_done  <= 1'b0;
      end else begin
         word_done <= 1'b0;
         case (link_state)
            LINK_IDLE: begin
               if (cs_fall) begin
                  link_state <= LINK_SHIFT;
                  bit_cnt    <= '0;
                  tx_shift   <= tx_hold;
               end
            end
            LINK_SHIFT: begin
               if (cs_q && cs_sync[2]) begin
                  // Frame ended early, partial word dropped
                  link_state <= LINK_IDLE;
               end else if (sclk_rise) begin
                  rx_shift <= {rx_shift[14:0], din_sync[2]};
                  bit_cnt  <= bit_cnt + 1'b1;
                  if (bit_cnt == 5'(WORD_BITS - 1)) begin
                     word_done  <= 1'b1;
                     link_state <= LINK_IDLE;
                  end
               end else if (sclk_fall && bit_cnt != '0) begin
                  tx_shift <= {tx_shift[14:0], 1'b0};
               end
            end
            default: link_state <= LINK_IDLE;
         endcase
      end
   end

   assign spi_dout    = tx_shift[15];
   assign spi_dout_oe = !cs_q;

   // Decode of the completed command word
   assign word     = rx_shift;
   assign cmd_addr = word[CMD_ADDR_LSB +: 7];

   // Register read view
   always_comb begin
      read_word = 16'h0000;
      case ({cmd_addr[6:1], 1'b0})
         ADDR_ACCEL_X_LOWER: read_word = offset_word[0];
         ADDR_ACCEL_X_UPPER: read_word = offset_word[1];
         ADDR_ACCEL_Y_LOWER: read_word = offset_word[2];
         ADDR_ACCEL_Y_UPPER: read_word = offset_word[3];
         ADDR_ACCEL_Z_LOWER: read_word = offset_word[4];
         ADDR_ACCEL_Z_UPPER: read_word = offset_word[5];
         ADDR_FILTER_SIZE:   read_word = filter_size;
         ADDR_GYRO_RANGE: begin
            read_word[RANGE_CODE_LSB +: 2] = GYRO_RANGE;
            read_word[1:0] = RANGE_LOW_FIXED;
         end
         ADDR_MISC_CONTROL:  read_word = misc_control;
         default:            read_word = 16'h0000;
      endcase
   end

   // Reply word for the next frame
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_hold <= 16'h0000;
      end else if (word_done) begin
         tx_hold <= word[CMD_WRITE_BIT] ? 16'h0000 : read_word;
      end
   end

   generate
      for (genvar i = 0; i < 6; i++) begin : g_offset
         localparam logic [6:0] WORD_ADDR = 7'(ADDR_ACCEL_X_LOWER + 2 * i);
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               offset_word[i] <= RST_OFFSET;
            end else if (word_done && word[CMD_WRITE_BIT] &&
                         cmd_addr[6:1] == WORD_ADDR[6:1]) begin
               if (cmd_addr[0]) offset_word[i][15:8] <= word[7:0];
               else offset_word[i][7:0] <= word[7:0];
            end
         end
      end
   endgenerate

   // filter size field, only B stored
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         filter_size  <= RST_FILTER_SIZE;
         filter_clear <= 1'b0;
      end else begin
         filter_clear <= 1'b0;
         if (word_done && word[CMD_WRITE_BIT] &&
             cmd_addr[6:1] == ADDR_FILTER_SIZE[6:1]) begin
            filter_clear <= 1'b1;
            if (!cmd_addr[0]) begin
               filter_size[FILTER_SIZE_MSB:0] <= word[FILTER_SIZE_MSB:0];
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         misc_control <= RST_MISC;
      end else if (word_done && word[CMD_WRITE_BIT] &&
                   cmd_addr[6:1] == ADDR_MISC_CONTROL[6:1] && !cmd_addr[0]) begin
         misc_control[7:0] <= word[7:0];
         misc_control[MISC_UNUSED_BIT] <= 1'b0;
      end
   end

   assign lin_g_comp_en = misc_control[MISC_LIN_G_BIT];
   assign pop_align_en  = misc_control[MISC_POP_BIT];
   assign sync_mode     = misc_control[MISC_SYNC_LSB +: 3];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_cnt  <= '0;
         int_tick <= 1'b0;
      end else begin
         int_tick <= 1'b0;
         if (div_cnt == ($clog2(SAMPLE_DIV))'(SAMPLE_DIV - 1)) begin
            div_cnt  <= '0;
            int_tick <= 1'b1;
         end else begin
            div_cnt <= div_cnt + 1'b1;
         end
      end
   end

   // active sync edge from polarity bit
   assign ext_edge = misc_control[MISC_SYNC_POL_BIT] ? syn_rise : syn_fall;

   always_comb begin
      case (sync_mode)
         SYNC_DIRECT, SYNC_SCALED, SYNC_PULSE: sample_tick = ext_edge;
         SYNC_INTERNAL, SYNC_OUTPUT:           sample_tick = int_tick;
         default:                              sample_tick = int_tick;
      endcase
   end

   // output sync drives the pin on each sample
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pulse_cnt <= '0;
      end else if (sync_mode == SYNC_OUTPUT && int_tick) begin
         pulse_cnt <= ($clog2(SYNC_PULSE_CYC+1))'(SYNC_PULSE_CYC);
      end else if (pulse_cnt != '0) begin
         pulse_cnt <= pulse_cnt - 1'b1;
      end
   end

   // output pulse level follows polarity bit
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sync_out <= 1'b0;
         sync_oe  <= 1'b0;
      end else begin
         sync_oe  <= (sync_mode == SYNC_OUTPUT);
         sync_out <= (pulse_cnt != '0) ~^ misc_control[MISC_SYNC_POL_BIT];
      end
   end

   // Per-axis bias add and two averaging stages
   generate
      for (genvar a = 0; a < 3; a++) begin : g_axis
         logic signed [SAMPLE_W-1:0] biased;
         logic signed [SAMPLE_W-1:0] mid_data;
         logic                       mid_valid;
         logic signed [SAMPLE_W-1:0] fin_data;
         // upper word on top, signed sum
         assign biased = $signed(raw_in[a]) +
                         $signed({offset_word[2*a+1], offset_word[2*a]});
         iab_avg_stage u_stage1 (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .clear     (filter_clear),
            .taps_log2 (filter_size[FILTER_SIZE_MSB:0]),
            .in_valid  (sample_tick),
            .in_data   (biased),
            .out_valid (mid_valid),
            .out_data  (mid_data)
         );
         iab_avg_stage u_stage2 (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .clear     (filter_clear),
            .taps_log2 (filter_size[FILTER_SIZE_MSB:0]),
            .in_valid  (mid_valid),
            .in_data   (mid_data),
            .out_valid (axis_valid[a]),
            .out_data  (fin_data)
         );
         assign axis_out[a] = fin_data;
      end
   endgenerate

   assign accel_x_out = axis_out[0];
   assign accel_y_out = axis_out[1];
   assign accel_z_out = axis_out[2];

   // Data valid flag, new data wins over a frame start
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dr_valid <= 1'b0;
      end else if (axis_valid[0]) begin
         dr_valid <= 1'b1;
      end else if (cs_fall) begin
         dr_valid <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_ready_output <= 1'b0;
      end else begin
         data_ready_output <= dr_valid ~^ misc_control[MISC_DR_POL_BIT];
      end
   end

endmodule : iab_accel_bias_regs

// ---- design/iab_pkg.sv ----
// Constants shared by the accelerometer bias register bank and its filter stage.
// Assumes a single 50 MHz system clock and 16-bit serial command words.
package iab_pkg;

   // Byte addresses of the register words (even byte is the low byte)
   localparam logic [6:0] ADDR_ACCEL_X_LOWER = 7'h4c;
   localparam logic [6:0] ADDR_ACCEL_X_UPPER = 7'h4e;
   localparam logic [6:0] ADDR_ACCEL_Y_LOWER = 7'h50;
   localparam logic [6:0] ADDR_ACCEL_Y_UPPER = 7'h52;
   localparam logic [6:0] ADDR_ACCEL_Z_LOWER = 7'h54;
   localparam logic [6:0] ADDR_ACCEL_Z_UPPER = 7'h56;
   localparam logic [6:0] ADDR_FILTER_SIZE   = 7'h5c;
   localparam logic [6:0] ADDR_GYRO_RANGE    = 7'h5e;
   localparam logic [6:0] ADDR_MISC_CONTROL  = 7'h60;

   // Reset values
   localparam logic [15:0] RST_OFFSET      = 16'h0000;
   localparam logic [15:0] RST_FILTER_SIZE = 16'h0000;
   localparam logic [15:0] RST_MISC        = 16'h00c1;

   // Field positions
   localparam int FILTER_SIZE_MSB   = 2;
   localparam int RANGE_CODE_LSB    = 2;
   localparam logic [1:0] RANGE_LOW_FIXED = 2'h3;
   localparam int MISC_LIN_G_BIT    = 7;
   localparam int MISC_POP_BIT      = 6;
   localparam int MISC_UNUSED_BIT   = 5;
   localparam int MISC_SYNC_LSB     = 2;
   localparam int MISC_SYNC_POL_BIT = 1;
   localparam int MISC_DR_POL_BIT   = 0;

   // Sync function codes
   localparam logic [2:0] SYNC_INTERNAL = 3'h0;
   localparam logic [2:0] SYNC_DIRECT   = 3'h1;
   localparam logic [2:0] SYNC_SCALED   = 3'h2;
   localparam logic [2:0] SYNC_OUTPUT   = 3'h3;
   localparam logic [2:0] SYNC_PULSE    = 3'h5;

   // Serial command word layout
   localparam int CMD_WRITE_BIT = 15;
   localparam int CMD_ADDR_LSB  = 8;
   localparam int WORD_BITS     = 16;

   // Filter stage geometry
   localparam int SAMPLE_W  = 32;
   localparam int TAP_DEPTH = 128;
   localparam int PTR_W     = 7;
   localparam int SUM_W     = SAMPLE_W + PTR_W;

   // Timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int CLK_HZ          = 50_000_000;
   localparam int SAMPLE_HZ       = 2000;
   localparam int SAMPLE_DIV_CYC  = CLK_HZ / SAMPLE_HZ;
   localparam int SYNC_PULSE_NS   = 500;
   localparam int SYNC_PULSE_CYC  = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Serial link states
   typedef enum logic {LINK_IDLE, LINK_SHIFT} iab_link_state_t;

endpackage : iab_pkg

// ---- design/iab_avg_stage.sv ----
// One moving-average stage with a run-time selectable power-of-two tap count.
// Assumes input samples arrive as one-cycle valid pulses on the system clock.
`timescale 1ns/10ps
module iab_avg_stage
   import iab_pkg::*;
(
   input  wire  logic                       ref_clk,
   input  wire  logic                       sys_rst,
   input  wire  logic                       clear,
   input  wire  logic [2:0]                 taps_log2,
   input  wire  logic                       in_valid,
   input  wire  logic signed [SAMPLE_W-1:0] in_data,
   output logic                             out_valid,
   output logic signed [SAMPLE_W-1:0]       out_data
);

   logic signed [SAMPLE_W-1:0] history [0:TAP_DEPTH-1];
   logic [PTR_W-1:0]           wr_ptr;
   logic [PTR_W:0]             fill;
   logic [PTR_W:0]             taps;
   logic signed [SAMPLE_W-1:0] oldest;
   logic signed [SUM_W-1:0]    sum;
   logic signed [SUM_W-1:0]    next_sum;
   logic signed [SUM_W-1:0]    next_avg;

   // Oldest sample leaving the window, zero until the window is full
   always_comb begin
      taps     = (PTR_W+1)'(1) << taps_log2;
      oldest   = (fill >= taps) ? history[wr_ptr - taps[PTR_W-1:0]] : '0;
      next_sum = sum + SUM_W'(in_data) - SUM_W'(oldest);
      next_avg = next_sum >>> taps_log2;
   end

   // Sample history, no reset needed
   always_ff @(posedge ref_clk) begin
      if (in_valid) begin
         history[wr_ptr] <= in_data;
      end
   end

   // Running sum and averaged output
   always_ff @(posedge ref_clk) begin
      if (sys_rst || clear) begin
         wr_ptr    <= '0;
         fill      <= '0;
         sum       <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            wr_ptr   <= wr_ptr + 1'b1;
            sum      <= next_sum;
            out_data <= next_avg[SAMPLE_W-1:0];
            if (fill != (PTR_W+1)'(TAP_DEPTH)) begin
               fill <= fill + 1'b1;
            end
         end
      end
   end

endmodule : iab_avg_stage

// ---- bench/iab_accel_bias_regs_asserts.sv ----
// Port checker for the accelerometer bias register bank.
// Assumes a bind onto the bank top; every check runs on the system clock.
`timescale 1ns/10ps
module iab_accel_bias_regs_asserts
   import iab_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_sclk,
   input  wire logic                spi_din,
   input  wire logic                spi_dout,
   input  wire logic                spi_dout_oe,
   input  wire logic                sync_in,
   input  wire logic                sync_out,
   input  wire logic                sync_oe,
   input  wire logic [SAMPLE_W-1:0] accel_x_in,
   input  wire logic [SAMPLE_W-1:0] accel_y_in,
   input  wire logic [SAMPLE_W-1:0] accel_z_in,
   input  wire logic [SAMPLE_W-1:0] accel_x_out,
   input  wire logic [SAMPLE_W-1:0] accel_y_out,
   input  wire logic [SAMPLE_W-1:0] accel_z_out,
   input  wire logic                data_ready_output,
   input  wire logic                lin_g_comp_en,
   input  wire logic                pop_align_en,
   input  wire logic [2:0]          sync_mode
);
   logic [3:0] idle_cnt;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // Cycles since the frame select went high, saturating
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !spi_cs_n) begin
         idle_cnt <= 4'h0;
      end else if (idle_cnt != 4'hf) begin
         idle_cnt <= idle_cnt + 4'h1;
      end
   end

   // Select held steady for the synchroniser depth
   sequence cs_idle_s;
      spi_cs_n [*6];
   endsequence
   sequence cs_busy_s;
      !spi_cs_n [*6];
   endsequence
   // Direct sync with no sync edge and no frame
   sequence quiet_s;
      (sync_mode == SYNC_DIRECT && $stable(sync_in) && idle_cnt > 4'h8) [*8];
   endsequence

   reset_defaults_a : assert property (disable iff (1'b0)
      sys_rst |=> lin_g_comp_en && pop_align_en && sync_mode == SYNC_INTERNAL
                  && !sync_oe && !data_ready_output)
      else $error("control outputs not at reset defaults");
   sync_drive_on_a : assert property ((sync_mode == SYNC_OUTPUT) [*3] |-> sync_oe)
      else $error("sync pin not driven in output sync mode");
   sync_drive_off_a : assert property ((sync_mode != SYNC_OUTPUT) [*3] |-> !sync_oe)
      else $error("sync pin driven outside output sync mode");
   reply_idle_a : assert property (cs_idle_s |-> !spi_dout_oe)
      else $error("reply driven while deselected");
   reply_busy_a : assert property (cs_busy_s |-> spi_dout_oe)
      else $error("reply not driven while selected");
   cfg_frame_only_a : assert property (
      !$stable({lin_g_comp_en, pop_align_en, sync_mode}) |-> idle_cnt < 4'h8)
      else $error("control changed without a frame");
   sample_hold_a : assert property (quiet_s |-> ##2 ($stable(accel_x_out)
      && $stable(accel_y_out) && $stable(accel_z_out)))
      else $error("outputs changed without a sample edge");
   ready_hold_a : assert property (quiet_s |-> ##2 $stable(data_ready_output))
      else $error("data ready changed without a sample edge");
   sync_pulse_a : assert property (
      sync_oe && idle_cnt > 4'h8 && $changed(sync_out) |=> $stable(sync_out) [*8])
      else $error("sync output pulse too short");
endmodule : iab_accel_bias_regs_asserts

// ---- bench/iab_host_model.sv ----
// Serial host that frames 16-bit command words to the bias register bank.
// Assumes mode 3 framing: clock parked high, data taken on rising clock edges.
`timescale 1ns/10ps
module iab_host_model (
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_din,
   input  wire logic spi_dout,
   input  wire logic spi_dout_oe
);
   // Idle bus: deselected, clock parked high
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b1;
      spi_din  = 1'b0;
   end

   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      #7;
      spi_cs_n = 1'b0;
      #200;
      for (int i = 15; i > 15 - nbits; i--) begin
         spi_sclk = 1'b0;
         spi_din  = tx[i];
         #80;
         spi_sclk = 1'b1;
         #80;
         // Reply bit read late, after the synchroniser delay
         rx[i]    = spi_dout_oe ? spi_dout : 1'bx;
      end
      spi_cs_n = 1'b1;
      spi_din  = ~spi_din; // Released line shows no stale value
      #393; // Frame spans whole clock periods
   endtask : xfer
endmodule : iab_host_model

// ---- bench/iab_accel_bias_regs_tb.sv ----
// Self-checking bench for the accelerometer bias register bank.
// Assumes the host model and port checker files are compiled first.
`timescale 1ns/10ps
module iab_accel_bias_regs_tb
   import iab_pkg::*;
;
   localparam logic [1:0]  RANGE_SET  = 2'h1;
   localparam logic [15:0] RANGE_WORD = {12'h000, RANGE_SET, RANGE_LOW_FIXED};

   logic                ref_clk, sys_rst, sync_in;
   logic                spi_cs_n, spi_sclk, spi_din, spi_dout, spi_dout_oe;
   logic                sync_out, sync_oe, data_ready_output, lin_g_comp_en, pop_align_en;
   logic [2:0]          sync_mode;
   logic [SAMPLE_W-1:0] accel_x_in, accel_y_in, accel_z_in;
   logic [SAMPLE_W-1:0] accel_x_out, accel_y_out, accel_z_out;
   logic [15:0]         rx_word;
   int                  num_errors = 0;
   int                  n_checks   = 0;
   int                  cyc        = 0;
   logic [6:0]  rst_addr [10] = '{7'h4c, 7'h4e, 7'h50, 7'h52, 7'h54, 7'h56, 7'h5c, 7'h5e,
                                  7'h60, 7'h70};
   logic [15:0] rst_val  [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                  16'h0000, 16'h0000, RANGE_WORD, 16'h00c1, 16'h0000};
   logic [15:0] bias_word [6] = '{16'h0005, 16'h0001, 16'hfffd, 16'hffff, 16'h8000, 16'h0001};
   logic [2:0]  sync_code [5] = '{SYNC_INTERNAL, SYNC_DIRECT, SYNC_SCALED, SYNC_OUTPUT,
                                  SYNC_PULSE};

   iab_accel_bias_regs #(.SAMPLE_DIV(50), .GYRO_RANGE(RANGE_SET)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .sync_in(sync_in),
      .sync_out(sync_out), .sync_oe(sync_oe), .accel_x_in(accel_x_in),
      .accel_y_in(accel_y_in), .accel_z_in(accel_z_in), .accel_x_out(accel_x_out),
      .accel_y_out(accel_y_out), .accel_z_out(accel_z_out),
      .data_ready_output(data_ready_output), .lin_g_comp_en(lin_g_comp_en),
      .pop_align_en(pop_align_en), .sync_mode(sync_mode));

   iab_host_model host_u (
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
      .spi_dout_oe(spi_dout_oe));

   // System clock, 20 ns period
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         $display("[FAIL] %0t run did not finish", $time);
         results();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      logic [15:0] rx;
      host_u.xfer({1'b1, addr, data}, 16, rx);
   endtask : wr

   // Read word, reply arrives in the following frame
   task automatic rdchk(input logic [6:0] addr, input logic [15:0] exp);
      logic [15:0] rx;
      host_u.xfer({1'b0, addr, 8'h00}, 16, rx);
      host_u.xfer(16'h0000, 16, rx);
      check({16'h0000, rx}, {16'h0000, exp}, "register read");
   endtask : rdchk

   task automatic sync_set(input logic v);
      @(posedge ref_clk);
      sync_in <= v;
   endtask : sync_set

   task automatic wait_dr(input logic lvl);
      int n;
      n = 0;
      while (data_ready_output !== lvl && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      check({31'h0, data_ready_output}, {31'h0, lvl}, "data ready level");
   endtask : wait_dr

   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   // Main sequence
   initial begin
      sys_rst    = 1'b1;
      sync_in    = 1'b0;
      accel_x_in = 32'h00000064;
      accel_y_in = 32'h00000064;
      accel_z_in = 32'h00000007;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         rdchk(rst_addr[i], rst_val[i]);
      end
      for (int i = 0; i < 6; i++) begin
         wr(rst_addr[i], bias_word[i][7:0]);
         wr(rst_addr[i] | 7'h01, bias_word[i][15:8]);
         rdchk(rst_addr[i], bias_word[i]);
      end
      // Read-only range word, then a frame cut short
      wr(ADDR_GYRO_RANGE, 8'h00);
      rdchk(ADDR_GYRO_RANGE, RANGE_WORD);
      host_u.xfer({1'b1, ADDR_ACCEL_X_LOWER, 8'haa}, 8, rx_word);
      rdchk(ADDR_ACCEL_X_LOWER, 16'h0005);
      wr(ADDR_FILTER_SIZE, 8'h04);
      wr(ADDR_FILTER_SIZE | 7'h01, 8'h00);
      rdchk(ADDR_FILTER_SIZE, 16'h0004);
      wr(ADDR_MISC_CONTROL, 8'h81);
      wr(ADDR_MISC_CONTROL | 7'h01, 8'h00);
      check({30'h0, lin_g_comp_en, pop_align_en}, 32'h2, "alignment off");
      rdchk(ADDR_MISC_CONTROL, 16'h0081);
      wr(ADDR_MISC_CONTROL, 8'h41);
      check({30'h0, lin_g_comp_en, pop_align_en}, 32'h1, "compensation off");
      // Documented sync codes only, unused bit kept zero
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_MISC_CONTROL, {3'b110, sync_code[i], 2'b11});
         if (sync_code[i] == SYNC_OUTPUT) repeat (120) @(posedge ref_clk);
         check({29'h0, sync_mode}, {29'h0, sync_code[i]}, "sync mode");
         check({31'h0, sync_oe}, {31'h0, sync_code[i] == SYNC_OUTPUT}, "sync oe");
      end
      // Direct sync on rising edges, single tap
      wr(ADDR_MISC_CONTROL, 8'hc7);
      wr(ADDR_FILTER_SIZE, 8'h00);
      sync_set(1'b1);
      wait_dr(1'b1);
      check(accel_x_out, 32'h00010069, "x out");
      check(accel_y_out, 32'h00000061, "y out");
      check(accel_z_out, 32'h00018007, "z out");
      // Two taps after a clear: both stages halve
      sync_set(1'b0);
      wr(ADDR_FILTER_SIZE, 8'h01);
      sync_set(1'b1);
      wait_dr(1'b1);
      check(accel_x_out, 32'h0000401a, "x two taps");
      check(accel_y_out, 32'h00000018, "y two taps");
      check(accel_z_out, 32'h00006001, "z two taps");
      sync_set(1'b0);
      repeat (20) @(posedge ref_clk);
      check(accel_x_out, 32'h0000401a, "falling edge ignored");
      // Falling edge selected, data ready active low
      wr(ADDR_MISC_CONTROL, 8'hc4);
      check({31'h0, data_ready_output}, 32'h1, "ready idle low polarity");
      sync_set(1'b1);
      repeat (20) @(posedge ref_clk);
      check(accel_x_out, 32'h0000401a, "rising edge ignored");
      sync_set(1'b0);
      wait_dr(1'b0);
      // Second reset in mid-run
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rdchk(ADDR_MISC_CONTROL, 16'h00c1);
      rdchk(ADDR_ACCEL_Z_UPPER, 16'h0000);
      results();
   end
endmodule : iab_accel_bias_regs_tb

bind iab_accel_bias_regs iab_accel_bias_regs_asserts chk_u (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
   .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .sync_in(sync_in),
   .sync_out(sync_out), .sync_oe(sync_oe), .accel_x_in(accel_x_in), .accel_y_in(accel_y_in),
   .accel_z_in(accel_z_in), .accel_x_out(accel_x_out), .accel_y_out(accel_y_out),
   .accel_z_out(accel_z_out), .data_ready_output(data_ready_output),
   .lin_g_comp_en(lin_g_comp_en), .pop_align_en(pop_align_en), .sync_mode(sync_mode));
